// *** common/imc_pkg.sv ***
// Constants and types for the LED driver control front end.
// Assumes a 20 MHz system clock; the serial link runs on its own clock.
package imc_pkg;
    // ************************************************
    // Timing
    // ************************************************
    localparam int CLK_MHZ = 20;
    localparam int START_US = 500;
    localparam int START_CYC = START_US * CLK_MHZ;
    localparam int IDLE_MS = 50;
    localparam int IDLE_CYC = IDLE_MS * 1000 * CLK_MHZ;
    localparam int FAST_CYC = 16;
    // ************************************************
    // Register map
    // ************************************************
    localparam logic [7:0] REG_ENABLE = 8'h00;
    localparam int CHIP_EN_BIT = 6;
    localparam logic [7:0] REG_GENCFG = 8'h36;
    localparam int INTCLK_BIT = 0;
    localparam int PWMPS_BIT = 2;
    localparam int PSAVE_BIT = 5;
    localparam int ADV_BIT = 6;
    localparam logic [7:0] REG_STATUS = 8'h3a;
    localparam logic [7:0] REG_CLEAR = 8'h3d;
    localparam logic [7:0] CLEAR_KEY = 8'hff;
    localparam logic [7:0] REG_PWM0 = 8'h16;
    localparam logic [7:0] REG_PWM_LAST = 8'h1e;
    localparam logic [7:0] REG_FADER0 = 8'h48;
    localparam logic [7:0] REG_GROUP0 = 8'h4c;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam int NREG = 128;
    localparam logic [6:0] ADDR_BASE = 7'h32;
    // ************************************************
    // States
    // ************************************************
    typedef enum logic [2:0] {
        M_RESET = 3'h0,
        M_STANDBY = 3'h1,
        M_STARTUP = 3'h2,
        M_NORMAL = 3'h3,
        M_PSAVE = 3'h4,
        M_WAKE = 3'h5
    } imc_mode_t;
    typedef enum logic [2:0] {
        L_IDLE = 3'h0,
        L_ADDR = 3'h1,
        L_IDX = 3'h2,
        L_WR = 3'h3,
        L_RD = 3'h4
    } imc_link_t;
endpackage

// *** design/imc_top.sv ***
// Serial target port, register file and mode sequencer of the LED driver.
// Assumes engines and PWM generator share clk_in; scl_in clocks the link.
// ************************************************
// Functional notes
// [RL1] Each of nine outputs has a host-writable duty register, active after reset.
// [RL2] An engine driving an output overrides that output's duty register.
// [RL3] Three master faders scale every output assigned to their group.
// [RL4] Automatic power save only while its general config enable bit is one.
// [RL5] External clock: most analog off in save; internal: only pump and drivers.
// [RL6] Either save variant puts the charge pump in weak unity keep-alive.
// [RL7] Save entered only if engines foresee no PWM for over 50 ms.
// [RL8] Engines keep running in save; PWM demand launches fast start-up.
// [RL9] Config bit 2 powers blocks down in each PWM off phase.
// [RL10] Per-cycle PWM saving also works while engines run programs.
// [RL11] FFH to the clear register or power-on reset restores all defaults.
// [RL12] After power-on reset the device goes to standby, chip enable cleared.
// [RL13] Chip enable or enable pin low keeps standby; registers stay writable.
// [RL14] Enable with pin high runs a 500 us start-up before normal.
// [RL15] Thermal cutoff holds the device in start-up until it clears.
// [RL16] Data changes only while the serial clock is low.
// [RL17] Master makes START and STOP; a repeated START equals a first.
// [RL18] Bytes are eight bits MSB first; the device acks on pulse nine.
// [RL19] Master ends a read by not acknowledging the last byte.
// [RL20] First byte is seven-bit address then direction, 0 write 1 read.
// [RL21] In writes, byte two picks the register, following bytes are stored.
// [RL22] Straps pick address 32, 33, 34 or 35 hex.
// [RL23] Address byte acked only when it matches the strapped address.
// [RL24] Index advances per byte when enabled, except within 16 to 1E.
// [RL25] Reads: write index, repeated START with read, NACK then STOP.
// [RL26] Data sampled on rising clock; START or STOP aborts a partial byte.
// ************************************************
`timescale 1ns/10ps
`default_nettype none
module imc_top #(
    parameter int NOUT = 9,
    parameter int START_CYC = imc_pkg::START_CYC,
    parameter int IDLE_CYC = imc_pkg::IDLE_CYC
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oen_out,
    input wire logic addr_strap_lo_in,
    input wire logic addr_strap_hi_in,
    input wire logic enable_pin_in,
    input wire logic thermal_cutoff_in,
    input wire logic [NOUT-1:0] eng_drive_in,
    input wire logic [8*NOUT-1:0] eng_duty_in,
    input wire logic [2:0] eng_quiet_in,
    input wire logic pwm_low_in,
    output logic [8*NOUT-1:0] duty_out,
    output logic [2:0] mode_out,
    output logic cp_weak_out,
    output logic drv_off_out,
    output logic analog_off_out,
    output logic cyc_drv_off_out,
    output logic cyc_analog_off_out
);
    // ************************************************
    // Link domain
    // ************************************************
    logic lr1_q, lr2_q;
    logic [1:0] as1_q, as2_q;
    logic [2:0] st1_q, st2_q;
    logic s_hi_q;
    logic [7:0] sh_q;
    logic [7:0] regs [imc_pkg::NREG];
    logic [3:0] cnt_q;
    imc_pkg::imc_link_t lst_q;
    logic [7:0] idx_q;
    logic [7:0] tx_q;
    logic rd_first_q;
    logic sda_oen_q;
    logic sda_q;
    logic upd_q;
    imc_pkg::imc_mode_t mode_q;

    // Reset, straps and status cross in as levels
    always_ff @(posedge scl_in) begin
        lr1_q <= resetn_in;
        lr2_q <= lr1_q;
        as1_q <= {addr_strap_hi_in, addr_strap_lo_in};
        as2_q <= as1_q;
        st1_q <= mode_q;
        st2_q <= st1_q;
    end

    always_ff @(posedge scl_in) begin
        s_hi_q <= sda_in; // RL26
        sh_q <= {sh_q[6:0], sda_in}; // RL18
    end

    function automatic logic [7:0] nxt(input logic [7:0] i, input logic adv);
        logic in_pwm;
        in_pwm = (i >= imc_pkg::REG_PWM0) && (i <= imc_pkg::REG_PWM_LAST);
        nxt = (adv && !in_pwm) ? 8'(i + 8'h01) : i; // RL24
    endfunction

    function automatic logic [7:0] rdb(input logic [7:0] i);
        if (i == imc_pkg::REG_STATUS) begin
            rdb = {5'h00, st2_q};
        end else if (i[7]) begin
            rdb = 8'h00;
        end else begin
            rdb = regs[i[6:0]];
        end
    endfunction

    logic [6:0] my_addr;
    logic adv_en;
    logic start_det, stop_det;
    logic [7:0] rd_idx;
    logic [7:0] rd_byte;
    assign my_addr = 7'(imc_pkg::ADDR_BASE + {5'h00, as2_q}); // RL22
    assign adv_en = regs[imc_pkg::REG_GENCFG[6:0]][imc_pkg::ADV_BIT];
    // SDA moved while SCL was high since the last rising edge
    assign start_det = s_hi_q & ~sda_in; // RL17
    assign stop_det = ~s_hi_q & sda_in;
    assign rd_idx = rd_first_q ? idx_q : nxt(idx_q, adv_en);
    assign rd_byte = rdb(rd_idx);

    // Drive changes only on falling SCL, so data is stable while high
    always_ff @(negedge scl_in) begin // RL16
        sda_q <= 1'b0;
        if (!lr2_q) begin
            for (int k = 0; k < imc_pkg::NREG; k++) begin
                regs[k] <= imc_pkg::REG_RST; // RL11
            end
            cnt_q <= 4'h0;
            lst_q <= imc_pkg::L_IDLE;
            idx_q <= 8'h00;
            tx_q <= 8'h00;
            rd_first_q <= 1'b0;
            sda_oen_q <= 1'b1;
            upd_q <= 1'b0;
        end else if (start_det) begin
            cnt_q <= 4'h0; // RL26
            lst_q <= imc_pkg::L_ADDR; // RL17
            sda_oen_q <= 1'b1;
        end else if (stop_det) begin
            cnt_q <= 4'h0; // RL26
            lst_q <= imc_pkg::L_IDLE;
            sda_oen_q <= 1'b1;
        end else if (lst_q != imc_pkg::L_IDLE) begin
            cnt_q <= (cnt_q == 4'h8) ? 4'h0 : 4'(cnt_q + 4'h1);
            if (cnt_q == 4'h7) begin
                case (lst_q)
                    imc_pkg::L_ADDR: begin
                        if (sh_q[7:1] == my_addr) begin // RL23
                            sda_oen_q <= 1'b0; // RL18
                            rd_first_q <= 1'b1;
                            lst_q <= sh_q[0] ? imc_pkg::L_RD : imc_pkg::L_IDX; // RL20
                        end else begin
                            sda_oen_q <= 1'b1;
                            lst_q <= imc_pkg::L_IDLE;
                        end
                    end
                    imc_pkg::L_IDX: begin
                        idx_q <= sh_q; // RL21
                        sda_oen_q <= 1'b0;
                        lst_q <= imc_pkg::L_WR;
                    end
                    imc_pkg::L_WR: begin
                        if (idx_q == imc_pkg::REG_CLEAR) begin
                            if (sh_q == imc_pkg::CLEAR_KEY) begin
                                for (int k = 0; k < imc_pkg::NREG; k++) begin
                                    regs[k] <= imc_pkg::REG_RST; // RL11
                                end
                            end
                        end else if (!idx_q[7]) begin
                            regs[idx_q[6:0]] <= sh_q; // RL21
                        end
                        upd_q <= ~upd_q;
                        idx_q <= nxt(idx_q, adv_en); // RL24
                        sda_oen_q <= 1'b0;
                    end
                    default: begin
                        sda_oen_q <= 1'b1; // Master's acknowledge slot
                    end
                endcase
            end else if (cnt_q == 4'h8) begin
                if (lst_q == imc_pkg::L_RD) begin
                    if (rd_first_q || !s_hi_q) begin // RL19
                        idx_q <= rd_idx; // RL24
                        tx_q <= {rd_byte[6:0], 1'b0};
                        sda_oen_q <= rd_byte[7];
                        rd_first_q <= 1'b0;
                    end else begin
                        lst_q <= imc_pkg::L_IDLE; // RL25
                        sda_oen_q <= 1'b1;
                    end
                end else begin
                    sda_oen_q <= 1'b1;
                end
            end else if (lst_q == imc_pkg::L_RD) begin
                sda_oen_q <= tx_q[7]; // RL18
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    assign sda_out = sda_q;
    assign sda_oen_out = sda_oen_q;

    chk_addr_nack: assert property (@(negedge scl_in) disable iff (!lr2_q) // RL23
        (!start_det && !stop_det && cnt_q == 4'h7 && lst_q == imc_pkg::L_ADDR
            && sh_q[7:1] != my_addr) |=> sda_oen_q && lst_q == imc_pkg::L_IDLE)
        else $error("address mismatch was acknowledged");

    // ************************************************
    // Register snapshot into system domain
    // ************************************************
    logic u1_q, u2_q, u3_q;
    logic en1_q, en2_q, tc1_q, tc2_q;
    logic chip_en_q;
    logic [7:0] cfg_q;
    logic [7:0] pwm_q [NOUT];
    logic [7:0] fad_q [3];
    logic [2*NOUT-1:0] grp_q;

    always_ff @(posedge clk_in) begin
        u1_q <= upd_q;
        u2_q <= u1_q;
        u3_q <= u2_q;
        en1_q <= enable_pin_in;
        en2_q <= en1_q;
        tc1_q <= thermal_cutoff_in;
        tc2_q <= tc1_q;
    end

    // Link registers are stable for a whole byte after each toggle
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            chip_en_q <= 1'b0; // RL12
            cfg_q <= imc_pkg::REG_RST;
            grp_q <= '0;
            for (int i = 0; i < NOUT; i++) begin
                pwm_q[i] <= imc_pkg::REG_RST;
            end
            for (int g = 0; g < 3; g++) begin
                fad_q[g] <= imc_pkg::REG_RST;
            end
        end else if (u2_q ^ u3_q) begin
            chip_en_q <= regs[imc_pkg::REG_ENABLE[6:0]][imc_pkg::CHIP_EN_BIT];
            cfg_q <= regs[imc_pkg::REG_GENCFG[6:0]];
            grp_q <= (2*NOUT)'({regs[7'(imc_pkg::REG_GROUP0 + 8'h2)],
                regs[7'(imc_pkg::REG_GROUP0 + 8'h1)], regs[imc_pkg::REG_GROUP0[6:0]]});
            for (int i = 0; i < NOUT; i++) begin
                pwm_q[i] <= regs[7'(imc_pkg::REG_PWM0 + 8'(i))]; // RL1
            end
            for (int g = 0; g < 3; g++) begin
                fad_q[g] <= regs[7'(imc_pkg::REG_FADER0 + 8'(g))]; // RL3
            end
        end
    end

    // ************************************************
    // Duty selection and fading
    // ************************************************
    // Full-scale fader (ff) leaves the duty unchanged
    function automatic logic [7:0] scale(input logic [7:0] d, input logic [7:0] f);
        logic [15:0] p;
        p = 16'({8'h00, d} * {8'h00, f}) + {8'h00, d};
        scale = p[15:8];
    endfunction

    function automatic logic [7:0] pick(input logic [7:0] s, input logic [1:0] g);
        pick = (g == 2'h0) ? s : scale(s, fad_q[2'(g - 2'h1)]); // RL3
    endfunction

    logic [8*NOUT-1:0] duty_q;
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            duty_q <= '0;
        end else begin
            for (int i = 0; i < NOUT; i++) begin
                duty_q[8*i+:8] <= pick(eng_drive_in[i] ? eng_duty_in[8*i+:8] // RL2
                    : pwm_q[i], grp_q[2*i+:2]); // RL1
            end
        end
    end
    assign duty_out = duty_q;

    chk_eng_override: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL2
        (eng_drive_in[0] && grp_q[1:0] == 2'h0) |=> duty_out[7:0] == $past(eng_duty_in[7:0]))
        else $error("engine duty did not override register");
    chk_direct_duty: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL1
        (!eng_drive_in[0] && grp_q[1:0] == 2'h0) |=> duty_out[7:0] == $past(pwm_q[0]))
        else $error("direct duty register not applied");

    // ************************************************
    // Mode sequencer
    // ************************************************
    logic [31:0] cnt_sq;
    logic [31:0] idl_q;
    logic on, any_act;
    assign on = chip_en_q & en2_q;
    assign any_act = |duty_q;

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            mode_q <= imc_pkg::M_RESET; // RL11
            cnt_sq <= 32'h0;
        end else if (mode_q != imc_pkg::M_RESET && !on) begin
            mode_q <= imc_pkg::M_STANDBY; // RL13
            cnt_sq <= 32'h0;
        end else begin
            case (mode_q)
                imc_pkg::M_RESET: begin
                    mode_q <= imc_pkg::M_STANDBY; // RL12
                end
                imc_pkg::M_STANDBY: begin
                    mode_q <= imc_pkg::M_STARTUP; // RL14
                    cnt_sq <= 32'h0;
                end
                imc_pkg::M_STARTUP: begin
                    if (tc2_q) begin
                        cnt_sq <= 32'h0; // RL15
                    end else if (cnt_sq == 32'(START_CYC - 1)) begin
                        mode_q <= imc_pkg::M_NORMAL; // RL14
                    end else begin
                        cnt_sq <= cnt_sq + 32'h1;
                    end
                end
                imc_pkg::M_NORMAL: begin
                    if (tc2_q) begin
                        mode_q <= imc_pkg::M_STARTUP;
                        cnt_sq <= 32'h0;
                    end else if (cfg_q[imc_pkg::PSAVE_BIT] && &eng_quiet_in // RL4
                        && idl_q >= 32'(IDLE_CYC)) begin
                        mode_q <= imc_pkg::M_PSAVE; // RL7
                    end
                end
                imc_pkg::M_PSAVE: begin
                    if (any_act || tc2_q || !cfg_q[imc_pkg::PSAVE_BIT]) begin
                        mode_q <= imc_pkg::M_WAKE; // RL8
                        cnt_sq <= 32'h0;
                    end
                end
                imc_pkg::M_WAKE: begin
                    if (cnt_sq == 32'(imc_pkg::FAST_CYC - 1)) begin
                        mode_q <= imc_pkg::M_STARTUP;
                        cnt_sq <= 32'(START_CYC - 1);
                    end else begin
                        cnt_sq <= cnt_sq + 32'h1;
                    end
                end
                default: begin
                    mode_q <= imc_pkg::M_STANDBY;
                end
            endcase
        end
    end

    // Engines keep running in save; only outputs idle long enough count
    always_ff @(posedge clk_in) begin
        if (!resetn_in || any_act || mode_q != imc_pkg::M_NORMAL) begin
            idl_q <= 32'h0; // RL7
        end else if (idl_q < 32'(IDLE_CYC)) begin
            idl_q <= idl_q + 32'h1;
        end
    end
    assign mode_out = mode_q;

    // ************************************************
    // Power controls
    // ************************************************
    logic cp_weak_q, drv_off_q, ana_off_q, cyc_drv_q, cyc_ana_q;
    logic int_clk, pwm_ps;
    assign int_clk = cfg_q[imc_pkg::INTCLK_BIT];
    assign pwm_ps = cfg_q[imc_pkg::PWMPS_BIT];

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            cp_weak_q <= 1'b0;
            drv_off_q <= 1'b1;
            ana_off_q <= 1'b0;
            cyc_drv_q <= 1'b0;
            cyc_ana_q <= 1'b0;
        end else begin
            cp_weak_q <= mode_q == imc_pkg::M_PSAVE; // RL6
            drv_off_q <= mode_q != imc_pkg::M_NORMAL; // RL5
            ana_off_q <= mode_q == imc_pkg::M_PSAVE && !int_clk; // RL5
            // Engine activity does not gate per-cycle saving
            cyc_drv_q <= pwm_ps && pwm_low_in && mode_q == imc_pkg::M_NORMAL; // RL9 RL10
            cyc_ana_q <= pwm_ps && pwm_low_in && mode_q == imc_pkg::M_NORMAL && !int_clk; // RL9
        end
    end
    assign cp_weak_out = cp_weak_q;
    assign drv_off_out = drv_off_q;
    assign analog_off_out = ana_off_q;
    assign cyc_drv_off_out = cyc_drv_q;
    assign cyc_analog_off_out = cyc_ana_q;

    chk_standby_when_off: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL13
        (!on && mode_q != imc_pkg::M_RESET) |=> mode_q == imc_pkg::M_STANDBY)
        else $error("not in standby while disabled");
    chk_thermal_hold: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL15
        (mode_q == imc_pkg::M_STARTUP && tc2_q) |=> mode_q != imc_pkg::M_NORMAL)
        else $error("left start-up during thermal cutoff");
    chk_startup_len: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL14
        (mode_q == imc_pkg::M_NORMAL && $past(mode_q) == imc_pkg::M_STARTUP)
            |-> $past(cnt_sq) == 32'(START_CYC - 1))
        else $error("start-up too short");
    chk_psave_gate: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL4
        (mode_q != imc_pkg::M_PSAVE && !cfg_q[imc_pkg::PSAVE_BIT])
            |=> mode_q != imc_pkg::M_PSAVE)
        else $error("power save entered while disabled");
    chk_weak_pump: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL6
        mode_q == imc_pkg::M_PSAVE |=> cp_weak_out && drv_off_out)
        else $error("pump not weak in power save");
    chk_ext_analog: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL5
        (mode_q == imc_pkg::M_PSAVE && !int_clk) |=> analog_off_out)
        else $error("analog left on with external clock");
    chk_cycle_save: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL9
        (pwm_ps && pwm_low_in && mode_q == imc_pkg::M_NORMAL) |=> cyc_drv_off_out)
        else $error("per-cycle save missing");
    chk_wake_fast: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL8
        (mode_q == imc_pkg::M_PSAVE && any_act && on && !tc2_q)
            |=> mode_q == imc_pkg::M_WAKE ##[1:20] mode_q == imc_pkg::M_STARTUP)
        else $error("no fast wake on activity");
endmodule
`default_nettype wire

// *** test/imc_master.sv ***
// Serial bus master model for the LED driver target port.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module imc_master (
    output logic scl_out,
    output logic sda_out,
    input wire logic sda_in
);
    // ****************************************
    // Bus conditions, clock idles high between frames
    // ****************************************
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // Also serves as repeated START; from idle a low pulse first ends the STOP
    task automatic start();
        if (scl_out) begin
            #8 scl_out = 1'b0;
        end
        #8 sda_out = 1'b1;
        #24 scl_out = 1'b1;
        #32 sda_out = 1'b0;
        #32 scl_out = 1'b0;
    endtask
    task automatic stop();
        #8 sda_out = 1'b0;
        #24 scl_out = 1'b1;
        #32 sda_out = 1'b1;
        #32;
    endtask
    // Data moves only while the clock is low
    task automatic bit_io(input logic b, output logic r);
        #8 sda_out = b;
        #24 scl_out = 1'b1;
        r = sda_in;
        #32 scl_out = 1'b0;
    endtask
    // nack=1 releases the ninth bit; ack reports a low ninth bit
    task automatic xfer(input logic [7:0] tx, input logic nack,
                        output logic [7:0] rx, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(nack, r);
        ack = ~r;
    endtask
endmodule
`default_nettype wire

// *** test/i2c_mode_power_control_test.sv ***
// Self-checking bench for the LED driver control front end.
// Assumes the master model in imc_master and short start-up/idle counts.
`timescale 1ns/10ps
`default_nettype none
module i2c_mode_power_control_test;
    logic clk_in = 1'b0, resetn_in = 1'b0, lo = 1'b0, hi = 1'b0;
    logic en_pin = 1'b0, therm = 1'b0, pwm_low = 1'b0, m_scl, m_sda;
    logic sda_out, sda_oen_out, cp_weak, drv_off, an_off, cyc_drv, cyc_ana, sda_w;
    logic [8:0] eng_drive = 9'h000;
    logic [71:0] eng_duty = 72'h0, duty;
    logic [2:0] eng_quiet = 3'h0, mode;
    logic [6:0] dev = 7'h32;
    int errors = 0, samples_checked = 0;
    always #25 clk_in = ~clk_in;
    assign sda_w = m_sda & (sda_oen_out ? 1'b1 : sda_out);
    imc_master u_imc_master (.scl_out(m_scl), .sda_out(m_sda), .sda_in(sda_w));
    imc_top #(.START_CYC(20), .IDLE_CYC(50)) u_imc_top (.clk_in(clk_in),
        .resetn_in(resetn_in), .scl_in(m_scl), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oen_out(sda_oen_out), .addr_strap_lo_in(lo), .addr_strap_hi_in(hi),
        .enable_pin_in(en_pin), .thermal_cutoff_in(therm), .eng_drive_in(eng_drive),
        .eng_duty_in(eng_duty), .eng_quiet_in(eng_quiet), .pwm_low_in(pwm_low),
        .duty_out(duty), .mode_out(mode), .cp_weak_out(cp_weak), .drv_off_out(drv_off),
        .analog_off_out(an_off), .cyc_drv_off_out(cyc_drv), .cyc_analog_off_out(cyc_ana));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic tally_and_finish();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [71:0] got, input logic [71:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
            errors++;
        end
    endtask
    task automatic clks(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic wait_mode(input logic [2:0] m, input int bound);
        int i;
        for (i = 0; i < bound && mode !== m; i++) clks(1);
        if (i == bound) begin
            check(mode, m);
            tally_and_finish();
        end
    endtask
    task automatic xw(input logic [7:0] b);
        logic [7:0] r;
        logic a;
        u_imc_master.xfer(b, 1'b1, r, a);
        check(a, 1'b1);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        u_imc_master.start();
        xw({dev, 1'b0});
        xw(idx);
        xw(d);
        u_imc_master.stop();
        clks(6);
    endtask
    task automatic expect_reg(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        logic a;
        u_imc_master.start();
        xw({dev, 1'b0});
        xw(idx);
        u_imc_master.start();
        xw({dev, 1'b1});
        u_imc_master.xfer(8'hff, 1'b1, d, a);
        u_imc_master.stop();
        check(d, exp);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_straps();
        logic [7:0] r;
        logic a;
        for (int k = 0; k < 4; k++) begin
            @(negedge clk_in) {hi, lo} = 2'(k);
            dev = 7'h32 + 7'(k);
            u_imc_master.start();
            u_imc_master.xfer({7'h32 + 7'((k + 1) % 4), 1'b0}, 1'b1, r, a);
            check(a, 1'b0);
            u_imc_master.start();
            xw({dev, 1'b0});
            u_imc_master.stop();
        end
        @(negedge clk_in) {hi, lo} = 2'b00;
        dev = 7'h32;
    endtask
    task automatic t_duty();
        wr(8'h16, 8'h5a);
        check(duty[7:0], 8'h5a);
        expect_reg(8'h16, 8'h5a);
        eng_duty[7:0] = 8'hc3;
        eng_drive = 9'h001;
        clks(3);
        check(duty[7:0], 8'hc3);
        eng_drive = 9'h000;
        clks(3);
        check(duty[7:0], 8'h5a);
    endtask
    task automatic t_incr();
        wr(8'h36, 8'h40);
        u_imc_master.start();
        xw({dev, 1'b0});
        xw(8'h17);
        xw(8'h33);
        xw(8'h44);
        u_imc_master.start();
        xw({dev, 1'b0});
        xw(8'h48);
        xw(8'h11);
        xw(8'h22);
        u_imc_master.stop();
        clks(6);
        check(duty[23:8], 16'h0044);
        expect_reg(8'h49, 8'h22);
        wr(8'h4c, 8'h01);
        check(duty[7:0], 8'h06);
        wr(8'h4c, 8'h00);
    endtask
    task automatic t_mode();
        en_pin = 1'b1;
        therm = 1'b1;
        wr(8'h00, 8'h40);
        wait_mode(imc_pkg::M_STARTUP, 20);
        clks(40);
        check(mode, imc_pkg::M_STARTUP);
        therm = 1'b0;
        clks(10);
        check(mode, imc_pkg::M_STARTUP);
        wait_mode(imc_pkg::M_NORMAL, 40);
        expect_reg(8'h3a, 8'h03);
        en_pin = 1'b0;
        wait_mode(imc_pkg::M_STANDBY, 10);
        en_pin = 1'b1;
        wait_mode(imc_pkg::M_NORMAL, 60);
    endtask
    task automatic t_save();
        wr(8'h16, 8'h00);
        wr(8'h17, 8'h00);
        eng_quiet = 3'h7;
        clks(80);
        check(mode, imc_pkg::M_NORMAL);
        wr(8'h36, 8'h60);
        wait_mode(imc_pkg::M_PSAVE, 200);
        check({cp_weak, an_off}, 2'b11);
        wr(8'h16, 8'h10);
        wait_mode(imc_pkg::M_NORMAL, 100);
        wr(8'h36, 8'h45);
        pwm_low = 1'b1;
        clks(4);
        check({cyc_drv, cyc_ana}, 2'b10);
        wr(8'h36, 8'h44);
        check({cyc_drv, cyc_ana}, 2'b11);
        pwm_low = 1'b0;
        wr(8'h3d, 8'hff);
        wait_mode(imc_pkg::M_STANDBY, 20);
        check(duty, 72'h0);
        expect_reg(8'h36, 8'h00);
    endtask
    initial begin
        u_imc_master.start();
        u_imc_master.stop();
        clks(1);
        resetn_in = 1'b1;
        clks(2);
        check({mode, drv_off, duty}, {imc_pkg::M_STANDBY, 1'b1, 72'h0});
        t_straps();
        t_duty();
        t_incr();
        t_mode();
        t_save();
        tally_and_finish();
    end
endmodule
`default_nettype wire
